//--- pkg/baud_test_pkg.sv
// Constants, register map and carrier types of the serial bit-rate self-test
package baud_test_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_CONTROL    = 8'h00;
    localparam logic [7:0] OFS_STATUS     = 8'h04;
    localparam logic [7:0] OFS_EXPECTED   = 8'h08;
    localparam logic [7:0] OFS_ACTUAL     = 8'h0C;
    localparam logic [7:0] OFS_TIMEOUT    = 8'h10;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
    localparam logic [7:0] OFS_IRQ_MASK   = 8'h18;

    // Field positions
    localparam int CTL_START_BIT  = 0;
    localparam int CTL_TEST_LSB   = 4;
    localparam int STS_BUSY_BIT   = 0;
    localparam int STS_PASS_BIT   = 1;
    localparam int STS_ERR_LSB    = 4;
    localparam int IRQ_DONE_BIT   = 0;
    localparam int IRQ_FAIL_BIT   = 1;
    localparam int SER_TRANSMIT_READY_FLAG_BIT  = 0;
    localparam int SER_RECEIVE_READY_FLAG_BIT  = 1;

    // Reset values
    localparam logic [15:0] TIMEOUT_RESET = 16'h1000;
    localparam logic [1:0]  IRQ_MASK_RESET = 2'h0;

    // Test pattern and result codes
    localparam logic [7:0]  TEST_CHAR      = 8'h55;
    localparam logic [15:0] CODE_TX_TMO    = 16'h6666;
    localparam logic [15:0] CODE_RX_TMO    = 16'h7777;
    localparam logic [15:0] CODE_BAD_DATA  = 16'h5555;
    localparam logic [2:0]  NUM_TESTS      = 3'h6;

    // Clock chain and tick timing
    localparam int CLK_NS        = 10;
    localparam int SOURCE_NS     = 250;
    localparam int SRC_CYCLES    = SOURCE_NS / CLK_NS;
    localparam int PRE_DIV       = 13;
    localparam int TICK_NS       = 16000;
    localparam int TICK_CYCLES   = TICK_NS / CLK_NS;

    typedef enum logic [2:0] {
        ERR_NONE, ERR_TX_TMO, ERR_RX_TMO, ERR_DATA, ERR_LOW, ERR_HIGH
    } err_t;

    // Per-test rate clock select (0:19.2k 1:38.4k 2:76.8k 3:153.6k) and divide
    localparam logic [1:0]  RATE_SEL [0:5] = '{2'h0, 2'h1, 2'h2, 2'h1, 2'h2, 2'h3};
    localparam logic        DIV_64   [0:5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    localparam logic [15:0] LIMIT_LO [0:5] = '{16'h07CE, 16'h03D5, 16'h01F0,
                                               16'h00F3, 16'h0083, 16'h0039};
    localparam logic [15:0] LIMIT_HI [0:5] = '{16'h085A, 16'h0425, 16'h0210,
                                               16'h0103, 16'h008B, 16'h0043};

    // Setup and data strobes towards one serial controller
    typedef struct packed {
        logic [1:0] rate_sel;
        logic       div64;
        logic       tx_enable;
        logic       tx_load;
        logic [7:0] tx_data;
    } ser_ctl_t;

endpackage

//--- rtl/baud_self_test.sv
// Serial bit-rate self-test sequencer with AHB-Lite register slave
//
// Summary of operation
// - Six tests, 300 to 9600 baud in order
// - Send 55h across loopback, time in ticks
// - Program rate select and divide, then enable
// - On transmit ready, start counter, load 55h
// - Transmit ready timeout reports 6666h actual
// - Poll receive ready, stop counter, read byte
// - Receive ready timeout reports 7777h actual
// - Wrong received byte reports 5555h actual
// - Below low limit: expected low, actual count
// - Above high limit: expected high, actual count
// - Within limits: count as expected and actual
// - Divide 64 below 2400 baud, else 16
// - Per-rate low and high count limits
// - 4 MHz to 307.7 kHz, counter to rates
// - Per-port rate multiplexer with latched selects
// - Ready flags read from controller status bytes
`timescale 1ns/10ps
module baud_self_test (
    // Clock and reset
    input  wire logic                       hclk,
    input  wire logic                       hresetn,
    // AHB-Lite slave
    input  wire logic                       hsel,
    input  wire logic [31:0]                haddr,
    input  wire logic [1:0]                 htrans,
    input  wire logic                       hwrite,
    input  wire logic [2:0]                 hsize,
    input  wire logic                       hready,
    input  wire logic [31:0]                hwdata,
    output logic      [31:0]                hrdata,
    output logic                            hreadyout,
    output logic                            hresp,
    // Master/slave port controller (transmitter)
    output baud_test_pkg::ser_ctl_t         ms_ctl,
    input  wire logic [7:0]                 ms_status,
    output logic                            ms_rate_clk,
    // Printer port controller (receiver)
    output baud_test_pkg::ser_ctl_t         prn_ctl,
    input  wire logic [7:0]                 prn_status,
    input  wire logic [7:0]                 prn_rx_data,
    output logic                            prn_rx_read,
    output logic                            prn_rate_clk,
    // Interrupt
    output logic                            irq
);
    import baud_test_pkg::*;

    typedef enum logic [3:0] {
        S_IDLE, S_PROGRAM, S_ENABLE, S_WAIT_TX, S_LOAD, S_WAIT_RX, S_READ, S_JUDGE, S_DONE
    } state_t;

    ////////////////////////////////////////////////////////////////////////////
    // Rate clock chain
    logic [4:0] src_cnt;
    logic [3:0] pre_cnt;
    logic [3:0] rate_cnt;
    wire        src_tick = (src_cnt == 5'(SRC_CYCLES - 1));
    wire        pre_tick = src_tick && (pre_cnt == 4'(PRE_DIV - 1));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            src_cnt  <= 5'h00;
            pre_cnt  <= 4'h0;
            rate_cnt <= 4'h0;
        end else begin
            src_cnt  <= src_tick ? 5'h00 : src_cnt + 5'h01;
            if (src_tick) begin
                pre_cnt <= pre_tick ? 4'h0 : pre_cnt + 4'h1;
            end
            if (pre_tick) begin
                rate_cnt <= rate_cnt + 4'h1;
            end
        end
    end

    // Counter bit 3 is 19.2 kHz down to bit 0 at 153.6 kHz
    wire [3:0] rate_taps = {rate_cnt[0], rate_cnt[1], rate_cnt[2], rate_cnt[3]};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ms_rate_clk  <= 1'b0;
            prn_rate_clk <= 1'b0;
        end else begin
            ms_rate_clk  <= rate_taps[ms_ctl.rate_sel];
            prn_rate_clk <= rate_taps[prn_ctl.rate_sel];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Elapsed tick prescaler
    logic [10:0] tick_cnt;
    wire         tick = (tick_cnt == 11'(TICK_CYCLES - 1));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_cnt <= 11'h000;
        end else begin
            tick_cnt <= tick ? 11'h000 : tick_cnt + 11'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    state_t      state;
    logic [2:0]  test_num;
    logic [15:0] elapsed;
    logic [15:0] timeout;
    logic [15:0] expected;
    logic [15:0] actual;
    err_t        err;
    logic [7:0]  rx_byte;
    logic [1:0]  irq_status;
    logic [1:0]  irq_mask;
    logic        fin;

    // Bus decode
    wire        addr_phase = hsel && hready && htrans[1];
    wire        rd_take    = addr_phase && !hwrite;
    logic       wr_pend;
    logic [7:0] wr_addr;
    wire        wr_ctl     = wr_pend && (wr_addr == OFS_CONTROL);
    wire        wr_tmo     = wr_pend && (wr_addr == OFS_TIMEOUT);
    wire        wr_mask    = wr_pend && (wr_addr == OFS_IRQ_MASK);
    wire [2:0]  wr_test    = hwdata[CTL_TEST_LSB +: 3];
    wire        start      = wr_ctl && hwdata[CTL_START_BIT] && (wr_test < NUM_TESTS)
                             && (state == S_IDLE);
    wire        rd_irq     = rd_take && (haddr[7:0] == OFS_IRQ_STATUS);

    wire [31:0] status_word = {25'h0, err, 2'h0, (err == ERR_NONE) && (state == S_IDLE),
                               state != S_IDLE};
    wire [31:0] rd_word =
        (haddr[7:0] == OFS_CONTROL)    ? {25'h0, test_num, 4'h0} :
        (haddr[7:0] == OFS_STATUS)     ? status_word :
        (haddr[7:0] == OFS_EXPECTED)   ? {16'h0, expected} :
        (haddr[7:0] == OFS_ACTUAL)     ? {16'h0, actual} :
        (haddr[7:0] == OFS_TIMEOUT)    ? {16'h0, timeout} :
        (haddr[7:0] == OFS_IRQ_STATUS) ? {30'h0, irq_status} :
        (haddr[7:0] == OFS_IRQ_MASK)   ? {30'h0, irq_mask} : 32'h0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend   <= 1'b0;
            wr_addr   <= 8'h00;
            hrdata    <= 32'h0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            timeout   <= TIMEOUT_RESET;
            irq_mask  <= IRQ_MASK_RESET;
        end else begin
            wr_pend   <= addr_phase && hwrite;
            wr_addr   <= haddr[7:0];
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (rd_take) begin
                hrdata <= rd_word;
            end
            if (wr_tmo) begin
                timeout <= hwdata[15:0];
            end
            if (wr_mask) begin
                irq_mask <= hwdata[1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer
    wire tx_ready = ms_status[SER_TRANSMIT_READY_FLAG_BIT];
    wire rx_ready = prn_status[SER_RECEIVE_READY_FLAG_BIT];
    wire timed_out = (elapsed >= timeout);
    wire [15:0] lim_lo = LIMIT_LO[test_num];
    wire [15:0] lim_hi = LIMIT_HI[test_num];
    wire        counting = (state == S_WAIT_TX) || (state == S_WAIT_RX);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= S_IDLE;
            test_num <= 3'h0;
            elapsed <= 16'h0000;
            expected <= 16'h0000;
            actual <= 16'h0000;
            err <= ERR_NONE;
            rx_byte <= 8'h00;
            fin <= 1'b0;
            ms_ctl <= '0;
            prn_ctl <= '0;
            prn_rx_read <= 1'b0;
        end else begin
            fin <= 1'b0;
            prn_rx_read <= 1'b0;
            ms_ctl.tx_load <= 1'b0;
            if (counting && tick && (elapsed != 16'hFFFF)) begin
                elapsed <= elapsed + 16'h0001;
            end
            unique case (state)
                S_IDLE: begin
                    if (start) begin
                        test_num <= wr_test;
                        state <= S_PROGRAM;
                    end
                end
                S_PROGRAM: begin
                    ms_ctl.rate_sel <= RATE_SEL[test_num];
                    prn_ctl.rate_sel <= RATE_SEL[test_num];
                    ms_ctl.div64 <= DIV_64[test_num];
                    prn_ctl.div64 <= DIV_64[test_num];
                    state <= S_ENABLE;
                end
                S_ENABLE: begin
                    ms_ctl.tx_enable <= 1'b1;
                    elapsed <= 16'h0000;
                    state <= S_WAIT_TX;
                end
                S_WAIT_TX: begin
                    if (tx_ready) begin
                        elapsed <= 16'h0000;
                        state <= S_LOAD;
                    end else if (timed_out) begin
                        err <= ERR_TX_TMO;
                        expected <= 16'h0000;
                        actual <= CODE_TX_TMO;
                        state <= S_DONE;
                    end
                end
                S_LOAD: begin
                    ms_ctl.tx_data <= TEST_CHAR;
                    ms_ctl.tx_load <= 1'b1;
                    state <= S_WAIT_RX;
                end
                S_WAIT_RX: begin
                    if (rx_ready) begin
                        prn_rx_read <= 1'b1;
                        state <= S_READ;
                    end else if (timed_out) begin
                        err <= ERR_RX_TMO;
                        expected <= 16'h0000;
                        actual <= CODE_RX_TMO;
                        state <= S_DONE;
                    end
                end
                S_READ: begin
                    rx_byte <= prn_rx_data;
                    state <= S_JUDGE;
                end
                S_JUDGE: begin
                    state <= S_DONE;
                    if (rx_byte != TEST_CHAR) begin
                        err <= ERR_DATA;
                        expected <= {8'h00, TEST_CHAR};
                        actual <= CODE_BAD_DATA;
                    end else if (elapsed < lim_lo) begin
                        err <= ERR_LOW;
                        expected <= lim_lo;
                        actual <= elapsed;
                    end else if (elapsed > lim_hi) begin
                        err <= ERR_HIGH;
                        expected <= lim_hi;
                        actual <= elapsed;
                    end else begin
                        err <= ERR_NONE;
                        expected <= elapsed;
                        actual <= elapsed;
                    end
                end
                S_DONE: begin
                    ms_ctl.tx_enable <= 1'b0;
                    fin <= 1'b1;
                    state <= S_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status: set wins over read-clear
    wire [1:0] irq_set   = {fin && (err != ERR_NONE), fin};
    wire [1:0] next_irqs = (rd_irq ? 2'h0 : irq_status) | irq_set;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_status <= 2'h0;
            irq <= 1'b0;
        end else begin
            irq_status <= next_irqs;
            irq <= |(next_irqs & irq_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_SEL_TABLE: assert property (state == S_ENABLE |->
        ms_ctl.rate_sel == RATE_SEL[test_num] && ms_ctl.div64 == DIV_64[test_num])
        else $error("rate select or divide wrong for test");
    AST_ENABLE_AFTER_PROG: assert property ($rose(ms_ctl.tx_enable) |->
        $past(state, 2) == S_PROGRAM)
        else $error("transmitter enabled before programming");
    AST_LOAD_CHAR: assert property (ms_ctl.tx_load |->
        ms_ctl.tx_data == 8'h55 && elapsed == 16'h0000 && $past(tx_ready, 2))
        else $error("load without ready or wrong character");
    AST_TX_TMO: assert property (state == S_WAIT_TX && !tx_ready && timed_out |=>
        state == S_DONE ##1 fin && actual == 16'h6666)
        else $error("transmit timeout code missing");
    AST_RX_READ: assert property (prn_rx_read |-> $past(rx_ready)
        ##1 state == S_JUDGE)
        else $error("receive read without ready");
    AST_RX_TMO: assert property (state == S_WAIT_RX && !rx_ready && timed_out |=>
        ##1 actual == 16'h7777 && err == ERR_RX_TMO)
        else $error("receive timeout code missing");
    AST_BAD_DATA: assert property (state == S_JUDGE && rx_byte != 8'h55 |=>
        actual == 16'h5555)
        else $error("data error code missing");
    AST_LOW: assert property (fin && err == ERR_LOW |->
        expected == LIMIT_LO[test_num] && actual < expected)
        else $error("low limit report wrong");
    AST_HIGH: assert property (fin && err == ERR_HIGH |->
        expected == LIMIT_HI[test_num] && actual > expected)
        else $error("high limit report wrong");
    AST_PASS: assert property (fin && err == ERR_NONE |->
        expected == actual && actual >= LIMIT_LO[test_num] && actual <= LIMIT_HI[test_num])
        else $error("pass report wrong");
    AST_SATURATE: assert property (elapsed == 16'hFFFF && counting |=>
        elapsed == 16'hFFFF || state != $past(state))
        else $error("elapsed counter wrapped");

endmodule

//--- tb/serial_loop_model.sv
// Loopback model of the two serial controllers behind the self-test
`timescale 1ns/10ps
module serial_loop_model
    import baud_test_pkg::*;
(
    // Clock and reset
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    // Sequencer side
    input  wire baud_test_pkg::ser_ctl_t ms_ctl,
    input  wire baud_test_pkg::ser_ctl_t prn_ctl,
    input  wire logic                  prn_rx_read,
    input  wire logic                  ms_rate_clk,
    output logic [7:0]                 ms_status,
    output logic [7:0]                 prn_status,
    output logic [7:0]                 prn_rx_data,
    // Behaviour set by the bench, a delay of zero means never ready
    input  wire logic [15:0]           tx_delay,
    input  wire logic [15:0]           rx_delay,
    input  wire logic [7:0]            rx_flip
);
    logic [15:0] tx_cnt, rx_cnt, cyc, last_rise, period;
    logic [7:0]  sent, junk;
    logic [2:0]  sel_seen, prn_seen;
    logic        loaded, taken, clk_q, en_q, tx_rdy, rx_full;

    assign tx_rdy = ms_ctl.tx_enable && tx_delay != 16'h0 && tx_cnt >= tx_delay && !loaded;
    assign rx_full = loaded && rx_delay != 16'h0 && rx_cnt >= rx_delay;
    // Other status bits toggle so that only the ready bits may matter
    assign ms_status = {junk[7:1], tx_rdy};
    assign prn_status = {junk[7:2], rx_full && !taken, junk[0]};
    // Outside a held byte the data lines show a moving pattern
    assign prn_rx_data = rx_full ? (sent ^ rx_flip) : junk;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {tx_cnt, rx_cnt, cyc, last_rise, period, sent, junk} <= '0;
            {sel_seen, prn_seen, loaded, taken, clk_q, en_q} <= '0;
        end else begin
            junk <= junk + 8'h5B;
            cyc <= cyc + 16'h1;
            en_q <= ms_ctl.tx_enable;
            clk_q <= ms_rate_clk;
            tx_cnt <= ms_ctl.tx_enable ? tx_cnt + 16'h1 : 16'h0;
            rx_cnt <= loaded ? rx_cnt + 16'h1 : 16'h0;
            if (ms_ctl.tx_enable && !en_q) begin
                sel_seen <= {ms_ctl.div64, ms_ctl.rate_sel};
                prn_seen <= {prn_ctl.div64, prn_ctl.rate_sel};
            end
            if (ms_ctl.tx_load) begin
                loaded <= 1'b1;
                sent <= ms_ctl.tx_data;
            end
            if (prn_rx_read) taken <= 1'b1;
            if (!ms_ctl.tx_enable) begin
                loaded <= 1'b0;
                taken <= 1'b0;
            end
            if (ms_rate_clk && !clk_q) begin
                period <= cyc - last_rise;
                last_rise <= cyc;
            end
        end
    end
endmodule

//--- tb/serial_baud_rate_self_test_bench.sv
// Self-checking bench of the serial bit-rate self-test sequencer
`timescale 1ns/10ps
module serial_baud_rate_self_test_bench;
    import baud_test_pkg::*;
    typedef struct {logic [31:0] exp; logic [31:0] mask;} note_t;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b1;
    logic [31:0] haddr = '0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = '0;
    logic [31:0] hrdata;
    logic        hreadyout, hresp, ms_rate_clk, prn_rate_clk, prn_rx_read, irq;
    logic [7:0]  ms_status, prn_status, prn_rx_data;
    logic [15:0] tx_delay = '0;
    logic [15:0] rx_delay = '0;
    logic [7:0]  rx_flip = '0;
    ser_ctl_t    ms_ctl, prn_ctl;
    note_t       notes[$];
    note_t       nt;
    logic        rd_open = 1'b0;
    int          num_errors = 0;
    int          comparisons = 0;

    always #5 hclk = ~hclk;

    baud_self_test baud_self_test_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .ms_ctl(ms_ctl), .ms_status(ms_status), .ms_rate_clk(ms_rate_clk),
        .prn_ctl(prn_ctl), .prn_status(prn_status), .prn_rx_data(prn_rx_data),
        .prn_rx_read(prn_rx_read), .prn_rate_clk(prn_rate_clk), .irq(irq));

    serial_loop_model serial_loop_model_inst (.hclk(hclk), .hresetn(hresetn),
        .ms_ctl(ms_ctl), .prn_ctl(prn_ctl), .prn_rx_read(prn_rx_read),
        .ms_rate_clk(ms_rate_clk), .ms_status(ms_status), .prn_status(prn_status),
        .prn_rx_data(prn_rx_data), .tx_delay(tx_delay), .rx_delay(rx_delay),
        .rx_flip(rx_flip));

    ////////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic give_up;
        num_errors++;
        $display("wait limit reached at %0t", $time);
        end_of_test();
    endtask

    // Read data is judged at the edge that closes its data phase
    always @(posedge hclk) begin
        if (rd_open && hreadyout === 1'b1) begin
            nt = notes.pop_front();
            check(hrdata & nt.mask, nt.exp);
            check(hresp, 1'b0);
        end
        if (hreadyout === 1'b1) rd_open <= hsel && htrans[1] && !hwrite;
    end

    task automatic wait_ready;
        int n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1) give_up();
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        notes.push_back('{e, m});
        bus(1'b0, a, 32'h0);
    endtask

    task automatic wait_enable(input logic lvl, input int lim);
        int n = 0;
        while (ms_ctl.tx_enable !== lvl && n < lim) begin
            @(posedge hclk);
            n++;
        end
        if (ms_ctl.tx_enable !== lvl) give_up();
    endtask

    ////////////////////////////////////////////////////////////////////////////////////
    task automatic run(input int t, input logic [15:0] txd, input logic [15:0] rxd,
                       input logic [7:0] flip, input logic [15:0] ex, input logic [15:0] ac,
                       input logic [15:0] am, input logic [2:0] er, input logic irq_on);
        tx_delay <= txd;
        rx_delay <= rxd;
        rx_flip <= flip;
        bus(1'b1, OFS_CONTROL, 32'(t) << CTL_TEST_LSB | 32'h1);
        check(irq, 1'b0);
        wait_enable(1'b1, 20);
        // A second start while busy must not take over
        bus(1'b1, OFS_CONTROL, 32'((t + 1) % 6) << CTL_TEST_LSB | 32'h1);
        wait_enable(1'b0, 60000);
        if (txd > 16'h03E8) check(serial_loop_model_inst.period, 32'h028A << (2'h3 - RATE_SEL[t]));
        check(prn_rate_clk, ms_rate_clk);
        repeat (3) @(posedge hclk);
        check(irq, irq_on);
        check({29'h0, serial_loop_model_inst.sel_seen}, {29'h0, DIV_64[t], RATE_SEL[t]});
        check({29'h0, serial_loop_model_inst.prn_seen}, {29'h0, DIV_64[t], RATE_SEL[t]});
        rd(OFS_STATUS, 32'(er) << STS_ERR_LSB, 32'h73);
        rd(OFS_EXPECTED, 32'(ex), 32'hFFFF);
        rd(OFS_ACTUAL, 32'(ac), 32'(am));
        rd(OFS_CONTROL, 32'(t) << CTL_TEST_LSB, 32'h70);
        rd(OFS_IRQ_STATUS, 32'h3, 32'h3);
        rd(OFS_IRQ_STATUS, 32'h0, 32'h3);
    endtask

    initial begin
        void'($urandom(32'hB42B0D94));
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(OFS_TIMEOUT, 32'(TIMEOUT_RESET), 32'hFFFF);
        rd(OFS_IRQ_MASK, 32'(IRQ_MASK_RESET), 32'h3);
        rd(8'h1C, 32'h0, 32'hFFFFFFFF);
        bus(1'b1, OFS_CONTROL, 32'h71);
        repeat (10) @(posedge hclk);
        check(ms_ctl.tx_enable, 1'b0);
        // Every rate ends quickly, below its low limit; the first with interrupts masked
        for (int t = 0; t < 6; t++) begin
            if (t == 1) bus(1'b1, OFS_IRQ_MASK, 32'h3);
            run(t, 16'h0514 + (16'h0514 << (2'h3 - RATE_SEL[t])), 16'(32'h64 + $urandom_range(32'h258)),
                8'h0, LIMIT_LO[t], 16'h0, 16'hFFFE, ERR_LOW, t != 0);
        end
        bus(1'b1, OFS_TIMEOUT, 32'h2);
        run(5, 16'h0, 16'h0, 8'h0, 16'h0, CODE_TX_TMO, 16'hFFFF, ERR_TX_TMO, 1'b1);
        run(4, 16'h012C, 16'h0, 8'h0, 16'h0, CODE_RX_TMO, 16'hFFFF, ERR_RX_TMO, 1'b1);
        run(3, 16'h012C, 16'h012C, 8'(32'h1 + $urandom_range(32'hFE)), 16'h0055, CODE_BAD_DATA,
            16'hFFFF, ERR_DATA, 1'b1);
        // Reset in mid-test abandons it and restores the register defaults
        tx_delay <= 16'h0;
        bus(1'b1, OFS_CONTROL, 32'h1);
        wait_enable(1'b1, 20);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        check({ms_ctl.tx_enable, irq, hreadyout}, 3'h1);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(OFS_TIMEOUT, 32'(TIMEOUT_RESET), 32'hFFFF);
        rd(OFS_STATUS, 32'h2, 32'h73);
        // Let the last read data phase be judged before the verdict
        repeat (2) @(posedge hclk);
        check(notes.size(), 0);
        end_of_test();
    end
endmodule
